// file: dv/smpc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module smpc_checker
    import smpc_pkg::*;
#(
    parameter int unsigned IO_OFF_DELAY    = IO_OFF_MIN,
    parameter int unsigned CLOCK_OFF_DELAY = CLOCK_OFF_MIN,
    parameter int unsigned IO_ON_DELAY     = IO_ON_MIN
) (
    // watched ports
    input wire logic                 ref_clk,
    input wire logic                 arst_n,
    input wire logic                 sleep_status,
    input wire logic [CLK_NET_N-1:0] global_clock_network_en,
    input wire logic                 io_buffer_en,
    input wire logic [CNT_W-1:0]     cnt_value,
    input wire logic [CNT_W-1:0]     cnt_sleep_enter,
    input wire logic [CNT_W-1:0]     cnt_sleep_exit,
    input wire logic [GPIO_N-1:0]    gpio_oe
);
    localparam int OFF_M1 = IO_OFF_DELAY - 1;
    localparam int OFF_W  = CLOCK_OFF_DELAY;
    localparam int ON_D   = IO_ON_DELAY;
    localparam int ON_D1  = IO_ON_DELAY + 1;
    logic [CLK_NET_N-1:0] ck;
    assign ck = global_clock_network_en;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    a_io_needs_status: assert property (
        !io_buffer_en |-> sleep_status)
        else $error("buffers off while status low");
    a_oe_follows_io: assert property (
        gpio_oe == {GPIO_N{io_buffer_en}})
        else $error("gpio enable differs from buffer enable");
    a_gate_shapes: assert property (
        ck inside {16'hffff, 16'hffc0, 16'hf800, 16'h0000, 16'h003f,
        16'h07ff}) else $error("clock enables out of order");
    a_io_off_delay: assert property (
        $rose(sleep_status) |-> ##OFF_M1 io_buffer_en ##1 !io_buffer_en)
        else $error("buffer off timing");
    a_gate_walk: assert property (
        $fell(io_buffer_en) |-> ##OFF_W ck == 16'hffff ##1 ck == 16'hffc0
        ##1 ck == 16'hf800 ##1 ck == 16'h0000)
        else $error("gating walk wrong");
    a_ungate_walk: assert property (
        $past(ck) == 16'h0000 && ck != 16'h0000 |-> ck == 16'h003f
        ##1 ck == 16'h07ff ##1 ck == 16'hffff)
        else $error("ungating walk wrong");
    a_cnt_steps: assert property (
        arst_n && !sleep_status |=> sleep_status ||
        cnt_value == $past(cnt_value) + 8'h01) else $error("count step");
    a_frozen_snap: assert property (ck == 16'h0000 |->
        cnt_value == cnt_sleep_enter) else $error("counter not frozen");
    a_exit_match: assert property ($fell(sleep_status) |->
        cnt_sleep_exit == cnt_sleep_enter && ck == 16'hffff)
        else $error("exit capture differs");
    a_io_on_delay: assert property ($rose(io_buffer_en) |->
        $fell(sleep_status) && $past(ck, ON_D) == 16'hffff &&
        $past(ck, ON_D1) != 16'hffff) else $error("buffer on timing");
endmodule // smpc_checker

bind smpc_top smpc_checker #(
    .IO_OFF_DELAY    (IO_OFF_DELAY),
    .CLOCK_OFF_DELAY (CLOCK_OFF_DELAY),
    .IO_ON_DELAY     (IO_ON_DELAY)
) i_smpc_checker (
    .ref_clk(ref_clk), .arst_n(arst_n), .sleep_status(sleep_status),
    .global_clock_network_en(global_clock_network_en),
    .io_buffer_en(io_buffer_en), .cnt_value(cnt_value),
    .cnt_sleep_enter(cnt_sleep_enter), .cnt_sleep_exit(cnt_sleep_exit),
    .gpio_oe(gpio_oe));
`default_nettype wire

// file: dv/smpc_sleep_req_model.sv
`timescale 1ns/1ps
`default_nettype none
module smpc_sleep_req_model (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       arst_n,
    // commands from the bench
    input  wire logic       go,
    input  wire logic [7:0] hold,
    // request pin and busy flag
    output var logic        sleep_req,
    output var logic        busy
);
    logic [7:0] left;
    // request stays high for hold+1 cycles
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sleep_req <= 1'b0;
            busy      <= 1'b0;
            left      <= 8'h00;
        end else if (go && !busy) begin
            sleep_req <= 1'b1;
            busy      <= 1'b1;
            left      <= hold;
        end else if (busy && left == 8'h00) begin
            sleep_req <= 1'b0;
            busy      <= 1'b0;
        end else begin
            left <= left - 8'h01;
        end
    end
endmodule // smpc_sleep_req_model
`default_nettype wire

// file: dv/smpc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module smpc_top_tb
    import smpc_pkg::*;
;
    logic                 ref_clk = 1'b0;
    logic                 arst_n = 1'b0;
    logic                 go = 1'b0;
    logic [7:0]           hold = 8'h00;
    logic                 sleep_req, busy, sleep_status, io_buffer_en;
    logic [CLK_NET_N-1:0] en;
    logic [CNT_W-1:0]     cnt, c_in, c_out;
    logic [GPIO_N-1:0]    g_out, g_oe;
    int                   n_errors = 0;
    int                   num_checks = 0;

    always #50 ref_clk = ~ref_clk;

    smpc_sleep_req_model i_smpc_sleep_req_model (.ref_clk(ref_clk),
        .arst_n(arst_n), .go(go), .hold(hold), .sleep_req(sleep_req),
        .busy(busy));
    smpc_top i_smpc_top (.ref_clk(ref_clk), .arst_n(arst_n),
        .sleep_req(sleep_req), .sleep_status(sleep_status),
        .global_clock_network_en(en), .io_buffer_en(io_buffer_en),
        .cnt_value(cnt), .cnt_sleep_enter(c_in), .cnt_sleep_exit(c_out),
        .gpio_out(g_out), .gpio_oe(g_oe));

    task automatic chk(input string nm, input logic [63:0] e,
                       input logic [63:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic rst_pulse();
        @(posedge ref_clk);
        arst_n <= 1'b0;
        repeat (3) @(negedge ref_clk);
        chk("reset", {2'b01, 16'hffff, 24'h0, 4'hf, 4'h0}, {sleep_status,
            io_buffer_en, en, cnt, c_in, c_out, g_oe, g_out});
        @(posedge ref_clk);
        arst_n <= 1'b1;
    endtask

    task automatic t_count();
        logic [CNT_W-1:0] a;
        @(negedge ref_clk);
        a = cnt;
        repeat (5) @(negedge ref_clk);
        a = a + 8'h05;
        chk("count", a, cnt);
        chk("gpio data", a[CNT_W-1 -: GPIO_N], g_out);
    endtask

    task automatic do_sleep(input logic [7:0] h, input bit timed,
                            input bit rst_mid);
        int n;
        logic [CNT_W-1:0] s;
        @(posedge ref_clk);
        go   <= 1'b1;
        hold <= h;
        @(posedge ref_clk);
        go <= 1'b0;
        n = 0;
        @(negedge ref_clk);
        // count runs through sync, fsm edge and both entry delays
        s = cnt + CNT_W'(3 + IO_OFF_MIN + CLOCK_OFF_MIN);
        while (sleep_status !== 1'b1 && n < 9) begin
            @(negedge ref_clk);
            n++;
        end
        chk("status rise", 3, n);
        @(negedge ref_clk);
        chk("io off", 0, io_buffer_en);
        while (en !== 16'h0000 && n < 40) begin
            @(negedge ref_clk);
            n++;
        end
        chk("asleep", {16'h0, 4'h0, s, s}, {en, g_oe, c_in, cnt});
        if (h > 8'h20) begin
            repeat (10) @(negedge ref_clk);
            chk("frozen", s, cnt);
        end
        if (rst_mid) begin
            rst_pulse();
            return;
        end
        while (busy !== 1'b0) @(negedge ref_clk);
        n = 0;
        while (io_buffer_en !== 1'b1 && n < 99) begin
            @(negedge ref_clk);
            n++;
        end
        if (timed)
            chk("wake time", 3 + CLOCK_ON_MIN + GATE_STEPS + IO_ON_MIN, n);
        chk("awake", {1'b0, 16'hffff, 4'hf}, {sleep_status, en, g_oe});
        chk("exit snap", s, c_out);
    endtask

    // a sleep cycle needs about a hundred cycles
    initial begin
        repeat (3000) @(posedge ref_clk);
        n_errors++;
        wrap_up();
    end

    initial begin
        rst_pulse();
        $display("reset test done");
        t_count();
        $display("count test done");
        do_sleep(8'h3c, 1'b1, 1'b0);
        $display("long sleep test done");
        do_sleep(8'h28, 1'b1, 1'b0);
        $display("back to back sleep test done");
        do_sleep(8'h03, 1'b0, 1'b0);
        $display("short request test done");
        do_sleep(8'h3c, 1'b0, 1'b1);
        $display("reset in sleep test done");
        t_count();
        $display("count after reset test done");
        wrap_up();
    end
endmodule // smpc_top_tb
`default_nettype wire

// file: src/smpc_ctl_if.sv
`timescale 1ns/1ps
`default_nettype none
interface smpc_ctl_if;
    logic run;
    logic take_enter;
    logic take_exit;
    logic io_en;
    modport ctl  (output run, output take_enter, output take_exit,
                  output io_en);
    modport user (input run, input take_enter, input take_exit,
                  input io_en);
endinterface
`default_nettype wire

// file: src/smpc_pkg.sv
package smpc_pkg;
    // delay fields and their least values, in clock cycles
    localparam int unsigned DELAY_W       = 6;
    localparam int unsigned DELAY_MAX     = 63;
    localparam int unsigned IO_OFF_MIN    = 1;
    localparam int unsigned CLOCK_OFF_MIN = 11;
    localparam int unsigned CLOCK_ON_MIN  = 1;
    localparam int unsigned IO_ON_MIN     = 40;

    // widths
    localparam int unsigned CLK_NET_N = 16;
    localparam int unsigned CNT_W     = 8;
    localparam int unsigned GPIO_N    = 4;

    // gating is spread over three cycles, low bits first
    localparam int unsigned GATE_STEPS  = 3;
    localparam int unsigned GATE_LIM_0  = 6;
    localparam int unsigned GATE_LIM_1  = 11;
    localparam int unsigned GATE_LIM_2  = 16;
    localparam logic [1:0]  STEP_FIRST  = 2'h0;
    localparam logic [1:0]  STEP_LAST   = 2'h2;

    typedef enum logic [2:0] {
        SMPC_AWAKE,
        SMPC_IO_OFF_WAIT,
        SMPC_CLK_OFF_WAIT,
        SMPC_CLK_GATE,
        SMPC_ASLEEP,
        SMPC_CLK_ON_WAIT,
        SMPC_CLK_UNGATE,
        SMPC_IO_ON_WAIT
    } smpc_state_e;
endpackage

// file: src/smpc_top.sv
// Notes on behaviour
// - sleep status rises the moment entry into sleep begins.
// - sleep status falls only once the wake sequence has fully finished.
// - user logic is a free-running 8-bit counter shown on an output.
// - counter value is captured and held on entry into sleep.
// - counter value is captured into a separate output on exit.
// - counter frozen while asleep, so both captures match after a cycle.
// - the four demonstration outputs are released while asleep.
// - each clock network is gated by driving its enable low.
// - a state machine sequences clocks and I/O buffers down and up.
// - on sleep, wait, buffers off, wait, clocks off low first in three.
// - on wake, wait, clocks on low first, wait, buffers on.
// - four 6-bit delays, least values 1, 11, 1 and 40 cycles.
`timescale 1ns/1ps
`default_nettype none
module smpc_top
    import smpc_pkg::*;
#(
    parameter int unsigned IO_OFF_DELAY    = IO_OFF_MIN,
    parameter int unsigned CLOCK_OFF_DELAY = CLOCK_OFF_MIN,
    parameter int unsigned CLOCK_ON_DELAY  = CLOCK_ON_MIN,
    parameter int unsigned IO_ON_DELAY     = IO_ON_MIN
) (
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 arst_n,
    // sleep request pin
    input  wire logic                 sleep_req,
    // power control
    output logic                      sleep_status,
    output logic [CLK_NET_N-1:0]      global_clock_network_en,
    output logic                      io_buffer_en,
    // demonstration user logic
    output logic [CNT_W-1:0]          cnt_value,
    output logic [CNT_W-1:0]          cnt_sleep_enter,
    output logic [CNT_W-1:0]          cnt_sleep_exit,
    output logic [GPIO_N-1:0]         gpio_out,
    output logic [GPIO_N-1:0]         gpio_oe
);
    // refuse delays below the least values or beyond the field
    if (IO_OFF_DELAY < IO_OFF_MIN || IO_OFF_DELAY > DELAY_MAX ||
        CLOCK_OFF_DELAY < CLOCK_OFF_MIN || CLOCK_OFF_DELAY > DELAY_MAX ||
        CLOCK_ON_DELAY < CLOCK_ON_MIN || CLOCK_ON_DELAY > DELAY_MAX ||
        IO_ON_DELAY < IO_ON_MIN || IO_ON_DELAY > DELAY_MAX) begin : g_chk
        $error("smpc_top: delay parameter out of range");
    end

    // groups must grow and the last step must cover every network
    if (GATE_LIM_0 >= GATE_LIM_1 || GATE_LIM_1 >= GATE_LIM_2 ||
        GATE_LIM_2 != CLK_NET_N) begin : g_chk_gate
        $error("smpc_top: gating groups do not cover the networks");
    end

    localparam logic [DELAY_W-1:0] IO_OFF_LOAD    = DELAY_W'(IO_OFF_DELAY - 1);
    localparam logic [DELAY_W-1:0] CLOCK_OFF_LOAD =
        DELAY_W'(CLOCK_OFF_DELAY - 1);
    localparam logic [DELAY_W-1:0] CLOCK_ON_LOAD  =
        DELAY_W'(CLOCK_ON_DELAY - 1);
    localparam logic [DELAY_W-1:0] IO_ON_LOAD     = DELAY_W'(IO_ON_DELAY - 1);

    // networks covered once a gating step is done, low bits first
    function automatic logic [CLK_NET_N-1:0] covered(input logic [1:0] step);
        logic [CLK_NET_N-1:0] m;
        m = '0;
        for (int unsigned i = 0; i < CLK_NET_N; i++) begin
            case (step)
                2'h0:    m[i] = (i < GATE_LIM_0);
                2'h1:    m[i] = (i < GATE_LIM_1);
                default: m[i] = (i < GATE_LIM_2);
            endcase
        end
        return m;
    endfunction

    // two-stage synchroniser for the request pin
    logic sleep_meta;
    logic sleep_sync;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sleep_meta <= 1'b0;
            sleep_sync <= 1'b0;
        end else begin
            sleep_meta <= sleep_req;
            sleep_sync <= sleep_meta;
        end
    end

    smpc_ctl_if ctl_if ();

    smpc_state_e          state;
    smpc_state_e          next_state;
    logic [DELAY_W-1:0]   timer;
    logic [DELAY_W-1:0]   next_timer;
    logic [1:0]           step;
    logic [1:0]           next_step;
    logic [CLK_NET_N-1:0] next_clk_en;
    logic                 next_io_en;
    logic                 next_status;
    logic                 run;
    logic                 next_run;
    logic                 take_enter;
    logic                 next_take_enter;
    logic                 take_exit;
    logic                 next_take_exit;

    always_comb begin
        next_state      = state;
        next_timer      = timer;
        next_step       = step;
        next_clk_en     = global_clock_network_en;
        next_io_en      = io_buffer_en;
        next_run        = run;
        next_take_enter = 1'b0;
        next_take_exit  = 1'b0;
        if (timer != '0) begin
            next_timer = timer - 6'h01;
        end
        case (state)
            SMPC_AWAKE: begin
                if (sleep_sync) begin
                    next_state = SMPC_IO_OFF_WAIT;
                    next_timer = IO_OFF_LOAD;
                end
            end
            SMPC_IO_OFF_WAIT: begin
                if (timer == '0) begin
                    next_io_en = 1'b0;
                    next_state = SMPC_CLK_OFF_WAIT;
                    next_timer = CLOCK_OFF_LOAD;
                end
            end
            SMPC_CLK_OFF_WAIT: begin
                if (timer == '0) begin
                    next_state      = SMPC_CLK_GATE;
                    next_step       = STEP_FIRST;
                    next_run        = 1'b0;
                    next_take_enter = 1'b1;
                end
            end
            SMPC_CLK_GATE: begin
                next_clk_en = ~covered(step);
                next_step   = step + 2'h1;
                if (step == STEP_LAST) begin
                    next_state = SMPC_ASLEEP;
                end
            end
            SMPC_ASLEEP: begin
                if (!sleep_sync) begin
                    next_state = SMPC_CLK_ON_WAIT;
                    next_timer = CLOCK_ON_LOAD;
                end
            end
            SMPC_CLK_ON_WAIT: begin
                if (timer == '0) begin
                    next_state = SMPC_CLK_UNGATE;
                    next_step  = STEP_FIRST;
                end
            end
            SMPC_CLK_UNGATE: begin
                next_clk_en = covered(step);
                next_step   = step + 2'h1;
                if (step == STEP_LAST) begin
                    next_state     = SMPC_IO_ON_WAIT;
                    next_timer     = IO_ON_LOAD;
                    next_run       = 1'b1;
                    next_take_exit = 1'b1;
                end
            end
            SMPC_IO_ON_WAIT: begin
                if (timer == '0) begin
                    next_io_en = 1'b1;
                    next_state = SMPC_AWAKE;
                end
            end
            default: begin
                next_state = SMPC_AWAKE;
            end
        endcase
        next_status = (next_state != SMPC_AWAKE);
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state                   <= SMPC_AWAKE;
            timer                   <= '0;
            step                    <= STEP_FIRST;
            global_clock_network_en <= '1;
            io_buffer_en            <= 1'b1;
            sleep_status            <= 1'b0;
            run                     <= 1'b1;
            take_enter              <= 1'b0;
            take_exit               <= 1'b0;
        end else begin
            state                   <= next_state;
            timer                   <= next_timer;
            step                    <= next_step;
            global_clock_network_en <= next_clk_en;
            io_buffer_en            <= next_io_en;
            sleep_status            <= next_status;
            run                     <= next_run;
            take_enter              <= next_take_enter;
            take_exit               <= next_take_exit;
        end
    end

    assign ctl_if.run        = run;
    assign ctl_if.take_enter = take_enter;
    assign ctl_if.take_exit  = take_exit;
    assign ctl_if.io_en      = io_buffer_en;

    smpc_user_logic u_user (
        .ref_clk         (ref_clk),
        .arst_n          (arst_n),
        .ctl             (ctl_if.user),
        .cnt_value       (cnt_value),
        .cnt_sleep_enter (cnt_sleep_enter),
        .cnt_sleep_exit  (cnt_sleep_exit),
        .gpio_out        (gpio_out),
        .gpio_oe         (gpio_oe)
    );
endmodule // smpc_top
`default_nettype wire

// file: src/smpc_user_logic.sv
`timescale 1ns/1ps
`default_nettype none
module smpc_user_logic
    import smpc_pkg::*;
(
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              arst_n,
    // control from the sequencer
    smpc_ctl_if.user               ctl,
    // demonstration outputs
    output logic [CNT_W-1:0]       cnt_value,
    output logic [CNT_W-1:0]       cnt_sleep_enter,
    output logic [CNT_W-1:0]       cnt_sleep_exit,
    output logic [GPIO_N-1:0]      gpio_out,
    output logic [GPIO_N-1:0]      gpio_oe
);
    logic [CNT_W-1:0]  next_cnt_value;
    logic [CNT_W-1:0]  next_cnt_sleep_enter;
    logic [CNT_W-1:0]  next_cnt_sleep_exit;
    logic [GPIO_N-1:0] next_gpio_out;

    always_comb begin
        next_cnt_value       = cnt_value;
        next_cnt_sleep_enter = cnt_sleep_enter;
        next_cnt_sleep_exit  = cnt_sleep_exit;
        if (ctl.run) begin
            next_cnt_value = cnt_value + 8'h01;
        end
        if (ctl.take_enter) begin
            next_cnt_sleep_enter = cnt_value;
        end
        if (ctl.take_exit) begin
            next_cnt_sleep_exit = cnt_value;
        end
        next_gpio_out = next_cnt_value[CNT_W-1 -: GPIO_N];
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_value       <= '0;
            cnt_sleep_enter <= '0;
            cnt_sleep_exit  <= '0;
            gpio_out        <= '0;
        end else begin
            cnt_value       <= next_cnt_value;
            cnt_sleep_enter <= next_cnt_sleep_enter;
            cnt_sleep_exit  <= next_cnt_sleep_exit;
            gpio_out        <= next_gpio_out;
        end
    end

    // pads released while the buffers are off
    assign gpio_oe = {GPIO_N{ctl.io_en}};
endmodule // smpc_user_logic
`default_nettype wire
